// File: rtl/csh_consts.svh
// Timing counts and reset values for the configuration status handshake
`ifndef CSH_CONSTS_SVH
`define CSH_CONSTS_SVH

// Power-on reset interval in microseconds and core_clk rate in MHz
`define CSH_POR_TIME_US     100
`define CSH_CLK_MHZ         40
`define CSH_POR_CYCLES      (`CSH_POR_TIME_US * `CSH_CLK_MHZ)
// Counter width for the power-on reset interval
`define CSH_POR_CNT_W       13
// Reset value of both synchroniser stages (line idle high via pull-up)
`define CSH_SYNC_RST        2'h3
// Reset value of the status edge history (idle level of the pin)
`define CSH_LINE_IDLE       1'b1

`endif

// File: rtl/csh_pkg.sv
// Types shared by the configuration status handshake
package csh_pkg;

    typedef enum logic [2:0]
    {
        CSH_POR     = 3'b000,
        CSH_WAIT    = 3'b001,
        CSH_LOAD    = 3'b010,
        CSH_INIT    = 3'b011,
        CSH_USER    = 3'b100,
        CSH_ERROR   = 3'b101,
        CSH_CLEARED = 3'b110
    } csh_state_t;

endpackage

// File: rtl/csh_sync_if.sv
// Synchronised pin levels passed from the input stage to the controller
`timescale 1ns/1ps
interface csh_sync_if;
    logic status_n;
    logic config_complete;
    logic config_req_n;

    modport src (output status_n, output config_complete, output config_req_n);
    modport dst (input status_n, input config_complete, input config_req_n);
endinterface

// File: rtl/csh_pin_sync.sv
// Two-stage synchronisers for the wired-AND status, completion and request pins
`timescale 1ns/1ps
`include "csh_consts.svh"
module csh_pin_sync
    import csh_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    input  wire logic   status_n_in,
    input  wire logic   config_complete_in,
    input  wire logic   config_req_n_in,
    csh_sync_if.src     sync
);

    logic [1:0] status_q;
    logic [1:0] complete_q;
    logic [1:0] req_q;

    // Only stage 1 is read out; stage 0 feeds stage 1 alone
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            status_q   <= `CSH_SYNC_RST;
            complete_q <= `CSH_SYNC_RST;
            req_q      <= `CSH_SYNC_RST;
        end
        else
        begin
            status_q   <= {status_q[0], status_n_in};
            complete_q <= {complete_q[0], config_complete_in};
            req_q      <= {req_q[0], config_req_n_in};
        end
    end

    assign sync.status_n        = status_q[1];
    assign sync.config_complete = complete_q[1];
    assign sync.config_req_n    = req_q[1];

endmodule

// File: rtl/csh_top.sv
// Configuration status handshake controller with open-drain status lines
// Contract
// - Status line held low after power-up, released after power-on reset interval.
// - Status and completion lines are open-drain; device only pulls them low.
// - Configuration error detected drives status line low.
// - External low on status during configuration or initialization means error state.
// - In user mode external status low is ignored; configuration kept.
// - Status line rising after power-on reset triggers a configuration attempt.
// - Completion line held low before and during data loading.
// - Completion line released once all data received error-free, initialization starts.
// - User mode entered only after all data received and completion sensed high.
// - In user mode external completion low is ignored.
// - Request input low clears configuration; returning high starts new configuration.
`timescale 1ns/1ps
`include "csh_consts.svh"
module csh_top
    import csh_pkg::*;
#(
    parameter int unsigned POR_CYCLES = `CSH_POR_CYCLES
)
(
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    input  wire logic   status_n_in,
    output logic        status_n_out,
    output logic        status_n_oe_n,
    input  wire logic   config_complete_in,
    output logic        config_complete_out,
    output logic        config_complete_oe_n,
    input  wire logic   config_req_n_in,
    input  wire logic   load_done,
    input  wire logic   load_error,
    input  wire logic   init_done,
    output logic        loading,
    output logic        initializing,
    output logic        user_mode,
    output logic        config_clear,
    output logic        error_flag
);

    csh_sync_if sync ();

    csh_pin_sync u_sync
    (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .status_n_in        (status_n_in),
        .config_complete_in (config_complete_in),
        .config_req_n_in    (config_req_n_in),
        .sync               (sync)
    );

    csh_state_t                     state_q;
    csh_state_t                     state_d;
    logic [`CSH_POR_CNT_W-1:0]      por_cnt_q;
    logic [`CSH_POR_CNT_W-1:0]      por_cnt_d;
    logic                           por_done;
    logic                           status_prev_q;
    logic                           status_rise;
    logic                           req_low;
    logic                           all_rx_q;
    logic                           all_rx_d;
    logic                           status_oe_n_d;
    logic                           complete_oe_n_d;
    logic                           loading_d;
    logic                           initializing_d;
    logic                           user_mode_d;
    logic                           config_clear_d;
    logic                           error_flag_d;

    // Loading or initialising: the window in which line lows are errors
    function automatic logic in_config(input csh_state_t s);
        return (s == CSH_LOAD) || (s == CSH_INIT);
    endfunction

    // States in which the device pulls the status line low
    function automatic logic drives_status(input csh_state_t s);
        return (s == CSH_POR) || (s == CSH_ERROR) || (s == CSH_CLEARED);
    endfunction

    // Completion stays low until initialisation starts
    function automatic logic drives_complete(input csh_state_t s);
        return (s != CSH_INIT) && (s != CSH_USER);
    endfunction

    // A configuration is held from loading through user mode
    function automatic logic holds_config(input csh_state_t s);
        return in_config(s) || (s == CSH_USER);
    endfunction

    assign por_done    = (por_cnt_q == `CSH_POR_CNT_W'(POR_CYCLES - 1));
    assign status_rise = sync.status_n && !status_prev_q;
    assign req_low     = !sync.config_req_n;

    // Power-on reset interval; rerun after every cleared configuration
    always_comb
    begin
        por_cnt_d = por_cnt_q;
        if (state_q == CSH_CLEARED)
            por_cnt_d = '0;
        else if (state_q == CSH_POR && !por_done)
            por_cnt_d = por_cnt_q + `CSH_POR_CNT_W'(1);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            por_cnt_q <= '0;
        else
            por_cnt_q <= por_cnt_d;
    end

    // Edge history starts at the idle level so reset makes no false rise
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            status_prev_q <= `CSH_LINE_IDLE;
        else
            status_prev_q <= sync.status_n;
    end

    // All data received without error; held through loading and initialisation, cleared in every other state
    always_comb
    begin
        all_rx_d = all_rx_q;
        if (!in_config(state_q))
            all_rx_d = 1'b0;
        else if (load_done && !load_error)
            all_rx_d = 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            all_rx_q <= 1'b0;
        else
            all_rx_q <= all_rx_d;
    end

    // Sequencer: a low request pin overrides every other cause in every state except CSH_POR
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            CSH_POR:
            begin
                if (por_done)
                    state_d = CSH_WAIT;
            end
            CSH_WAIT:
            begin
                if (req_low)
                    state_d = CSH_CLEARED;
                else if (status_rise || sync.status_n)
                    state_d = CSH_LOAD;
            end
            CSH_LOAD:
            begin
                if (req_low)
                    state_d = CSH_CLEARED;
                else if (load_error)
                    state_d = CSH_ERROR;
                else if (!sync.status_n)
                    state_d = CSH_ERROR;
                else if (load_done)
                    state_d = CSH_INIT;
            end
            CSH_INIT:
            begin
                if (req_low)
                    state_d = CSH_CLEARED;
                else if (!sync.status_n)
                    state_d = CSH_ERROR;
                else if (all_rx_q && sync.config_complete && init_done)
                    state_d = CSH_USER;
            end
            CSH_USER:
            begin
                if (req_low)
                    state_d = CSH_CLEARED;
            end
            CSH_ERROR:
            begin
                if (req_low)
                    state_d = CSH_CLEARED;
                else if (status_rise)
                    state_d = CSH_LOAD;
            end
            CSH_CLEARED:
            begin
                if (!req_low)
                    state_d = CSH_POR;
            end
            default:
            begin
                state_d = CSH_POR;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            state_q <= CSH_POR;
        else
            state_q <= state_d;
    end

    // Outputs follow the next state so they change with the transition
    always_comb
    begin
        status_oe_n_d   = !drives_status(state_d);
        complete_oe_n_d = !drives_complete(state_d);
        loading_d       = (state_d == CSH_LOAD);
        initializing_d  = (state_d == CSH_INIT);
        user_mode_d     = (state_d == CSH_USER);
        config_clear_d  = !holds_config(state_d);
        error_flag_d    = (state_d == CSH_ERROR);
    end

    // Open-drain data is always low; only the enables move
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            status_n_out <= 1'b0;
        else
            status_n_out <= 1'b0;
    end

    // Enable low while the device pulls the line
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            status_n_oe_n <= 1'b0;
        else
            status_n_oe_n <= status_oe_n_d;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            config_complete_out <= 1'b0;
        else
            config_complete_out <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            config_complete_oe_n <= 1'b0;
        else
            config_complete_oe_n <= complete_oe_n_d;
    end

    // Status outputs toward the core
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            loading <= 1'b0;
        else
            loading <= loading_d;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            initializing <= 1'b0;
        else
            initializing <= initializing_d;
    end

    // User mode only after completion sensed high
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            user_mode <= 1'b0;
        else
            user_mode <= user_mode_d;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            config_clear <= 1'b1;
        else
            config_clear <= config_clear_d;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            error_flag <= 1'b0;
        else
            error_flag <= error_flag_d;
    end

endmodule

// File: tb/csh_top_chk.sv
// Port assertions for the configuration status handshake
`timescale 1ns/1ps
module csh_top_chk
    import csh_pkg::*;
#(
    parameter int unsigned POR_CYCLES = 8
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic status_n_in,
    input wire logic status_n_out,
    input wire logic status_n_oe_n,
    input wire logic config_complete_out,
    input wire logic config_complete_oe_n,
    input wire logic config_req_n_in,
    input wire logic init_done,
    input wire logic loading,
    input wire logic initializing,
    input wire logic user_mode,
    input wire logic config_clear,
    input wire logic error_flag
);
    int unsigned por_q;

    // Cycles since reset release, saturating
    always_ff @(posedge core_clk)
        if (!rst_n)
            por_q <= 0;
        else if (por_q < POR_CYCLES)
            por_q <= por_q + 1;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence req_held;
        (!config_req_n_in) [*3];
    endsequence

    sequence req_quiet;
        config_req_n_in [*3];
    endsequence

    open_drain_a: assert property (!status_n_out && !config_complete_out)
        else $error("line driven high");
    por_hold_a: assert property (por_q < POR_CYCLES |-> !status_n_oe_n)
        else $error("status released early");
    por_release_a: assert property ($rose(por_q == POR_CYCLES) |-> ##[0:3] status_n_oe_n)
        else $error("status not released");
    load_low_a: assert property (loading |-> !config_complete_oe_n)
        else $error("completion released in load");
    init_release_a: assert property (initializing |-> config_complete_oe_n)
        else $error("completion held in init");
    user_entry_a: assert property ($rose(user_mode) |-> $past(initializing) && $past(init_done))
        else $error("user mode too early");
    err_drive_a: assert property (error_flag |-> !status_n_oe_n)
        else $error("error not driven");
    ext_error_a: assert property (loading && !status_n_in |-> ##[1:3] error_flag)
        else $error("external low missed");
    user_hold_a: assert property (req_quiet ##0 user_mode |=> user_mode)
        else $error("user mode lost");
    req_clear_a: assert property (req_held |=> config_clear && !user_mode)
        else $error("request not cleared");
endmodule

// File: tb/csh_host_model.sv
// Configuration host with pull-ups on the open-drain lines
`timescale 1ns/1ps
module csh_host_model
    import csh_pkg::*;
(
    input wire logic status_n_out,
    input wire logic status_n_oe_n,
    input wire logic config_complete_out,
    input wire logic config_complete_oe_n,
    input wire logic hold_status,
    input wire logic hold_done,
    input wire logic reconfig,
    output logic     status_w,
    output logic     done_w,
    output logic     config_req_n
);
    // Pull-up gives high unless someone pulls low
    assign status_w = (status_n_oe_n ? 1'b1 : status_n_out) & !hold_status;
    assign done_w = (config_complete_oe_n ? 1'b1 : config_complete_out) & !hold_done;
    assign config_req_n = !reconfig;
endmodule

// File: tb/config_status_handshake_bench.sv
// Self-checking bench for the status handshake
`timescale 1ns/1ps
module config_status_handshake_bench import csh_pkg::*;;
    logic core_clk = 0, rst_n = 0, load_done = 0, load_error = 0, init_done = 0;
    logic hold_s = 0, hold_d = 0, reconfig = 0;
    wire  status_w, done_w, req_n, s_out, s_oe_n, d_out, d_oe_n;
    wire  loading, initializing, user_mode, config_clear, error_flag;
    wire  [3:0] st = {error_flag, user_mode, initializing, loading};
    int   fails = 0, num_checks = 0, cyc = 0;

    always #12.5 core_clk = ~core_clk;

    csh_top #(.POR_CYCLES(8)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .status_n_in(status_w),
        .status_n_out(s_out), .status_n_oe_n(s_oe_n), .config_complete_in(done_w),
        .config_complete_out(d_out), .config_complete_oe_n(d_oe_n), .config_req_n_in(req_n),
        .load_done(load_done), .load_error(load_error), .init_done(init_done), .loading(loading),
        .initializing(initializing), .user_mode(user_mode), .config_clear(config_clear),
        .error_flag(error_flag));
    csh_host_model u_host (.status_n_out(s_out), .status_n_oe_n(s_oe_n), .config_complete_out(d_out),
        .config_complete_oe_n(d_oe_n), .hold_status(hold_s), .hold_done(hold_d),
        .reconfig(reconfig), .status_w(status_w), .done_w(done_w), .config_req_n(req_n));

    task stop_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input string nm, input logic e, input logic s);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %b got %b", nm, e, s);
        end
    endtask

    task wait_st(input int k);
        int n;
        n = 0;
        while (st[k] !== 1'b1 && n < 60)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            stop_test;
        end
    end

    task t_por;
        repeat (4) @(negedge core_clk);
        chk("status", 1'b0, status_w);
        chk("s_out", 1'b0, s_out);
        chk("d_out", 1'b0, d_out);
        wait_st(0);
        chk("loading", 1'b1, loading);
        chk("done", 1'b0, done_w);
        $display("por test done");
    endtask

    task t_load;
        load_done = 1'b1;
        @(negedge core_clk);
        load_done = 1'b0;
        wait_st(1);
        chk("done_oe_n", 1'b1, d_oe_n);
        chk("init", 1'b1, initializing);
        repeat (4) @(negedge core_clk);
        chk("early_user", 1'b0, user_mode);
        hold_d = 1'b1;
        repeat (3) @(negedge core_clk);
        init_done = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("held_user", 1'b0, user_mode);
        hold_d = 1'b0;
        wait_st(2);
        init_done = 1'b0;
        chk("clear", 1'b0, config_clear);
        $display("load test done");
    endtask

    task t_ignore;
        hold_s = 1'b1;
        hold_d = 1'b1;
        repeat (10) @(negedge core_clk);
        chk("user", 1'b1, user_mode);
        chk("err", 1'b0, error_flag);
        hold_s = 1'b0;
        hold_d = 1'b0;
        $display("ignore test done");
    endtask

    task t_reconf;
        reconfig = 1'b1;
        repeat (5) @(negedge core_clk);
        chk("clear", 1'b1, config_clear);
        chk("done", 1'b0, done_w);
        reconfig = 1'b0;
        wait_st(0);
        chk("reload", 1'b1, loading);
        $display("reconfig test done");
    endtask

    task t_load_err;
        load_error = 1'b1;
        @(negedge core_clk);
        load_error = 1'b0;
        wait_st(3);
        chk("status", 1'b0, status_w);
        $display("error test done");
    endtask

    task t_ext;
        hold_s = 1'b1;
        wait_st(3);
        hold_s = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("err", 1'b1, error_flag);
        chk("status", 1'b0, status_w);
        $display("external test done");
    endtask

    initial
    begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        t_por;
        t_load;
        t_ignore;
        t_reconf;
        t_load_err;
        t_reconf;
        t_ext;
        stop_test;
    end
endmodule

bind csh_top csh_top_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (.*);
